/* rtl/lock_pkg.sv */
// shared constants for the hub lock semaphores and shared memory port
package lock_pkg;

    // ------------------------------------------------------------
    // lock pool
    // ------------------------------------------------------------
    localparam int LOCK_COUNT = 8;
    localparam int LOCK_IDX_W = 3;
    localparam logic [LOCK_COUNT-1:0] LOCK_BITS_RESET = 8'h00;
    localparam logic [LOCK_COUNT-1:0] TAKEN_BITS_RESET = 8'h00;

    // ------------------------------------------------------------
    // operation codes carried on the request ports
    // ------------------------------------------------------------
    localparam int OP_W = 3;
    localparam logic [OP_W-1:0] OP_ALLOC = 3'h0;
    localparam logic [OP_W-1:0] OP_RELEASE = 3'h1;
    localparam logic [OP_W-1:0] OP_SET = 3'h2;
    localparam logic [OP_W-1:0] OP_CLEAR = 3'h3;
    localparam logic [OP_W-1:0] OP_MEM_RD = 3'h4;
    localparam logic [OP_W-1:0] OP_MEM_WR = 3'h5;

    // ------------------------------------------------------------
    // answer encoding: index, previous bit, or minus one
    // ------------------------------------------------------------
    localparam int RESULT_W = 4;
    localparam logic [RESULT_W-1:0] RESULT_NONE = 4'hF;
    localparam logic [RESULT_W-1:0] RESULT_RESET = 4'h0;

    // ------------------------------------------------------------
    // shared memory
    // ------------------------------------------------------------
    localparam int WORD_W = 32;
    localparam int LANE_W = 8;
    localparam int LANES = 4;
    localparam int MEM_DEPTH_DEFAULT = 256;
    localparam int CORES_DEFAULT = 8;
    localparam logic [LANE_W-1:0] LANE_RESET = 8'h00;

endpackage

/* rtl/hub_rr_arbiter.sv */
// round-robin grant of one requester per cycle
`timescale 1ns/1ps
module hub_rr_arbiter #(
    parameter int N = 8,
    parameter int IW = $clog2(N)
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // requests and grant
    input wire logic [N-1:0] req_in,
    output logic grant_valid_out,
    output logic [IW-1:0] grant_idx_out
);
    typedef struct packed {
        logic [IW-1:0] ptr;
    } arb_state_t;

    arb_state_t st_q;
    arb_state_t st_d;
    logic [IW-1:0] cand;

    always_comb begin
        st_d = st_q;
        cand = '0;
        grant_valid_out = 1'b0;
        grant_idx_out = '0;
        // search starts after the last winner so no core starves
        for (int i = 0; i < N; i++) begin
            cand = IW'((int'(st_q.ptr) + i) % N);
            if (!grant_valid_out && req_in[cand]) begin
                grant_valid_out = 1'b1;
                grant_idx_out = cand;
            end
        end
        if (grant_valid_out) begin
            st_d.ptr = IW'((int'(grant_idx_out) + 1) % N);
        end
        if (!resetn_in) begin
            st_d.ptr = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        st_q <= st_d;
    end
endmodule

/* rtl/hub_shared_ram.sv */
// byte-lane shared memory with registered read data
`timescale 1ns/1ps
module hub_shared_ram
    import lock_pkg::*;
#(
    parameter int DEPTH = lock_pkg::MEM_DEPTH_DEFAULT,
    parameter int AW = $clog2(DEPTH)
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // access port
    input wire logic en_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [lock_pkg::LANES-1:0] be_in,
    input wire logic [lock_pkg::WORD_W-1:0] wdata_in,
    output logic [lock_pkg::WORD_W-1:0] rdata_out
);
    genvar l;
    generate
        for (l = 0; l < LANES; l++) begin : g_lane
            logic [LANE_W-1:0] lane_mem [DEPTH];
            logic [LANE_W-1:0] rd_q;
            always_ff @(posedge clk_in) begin
                if (en_in && we_in && be_in[l]) begin
                    lane_mem[addr_in] <= wdata_in[l*LANE_W +: LANE_W];
                end
            end
            // read-before-write: a write returns the old lane contents
            always_ff @(posedge clk_in) begin
                if (!resetn_in) begin
                    rd_q <= LANE_RESET;
                end else if (en_in) begin
                    rd_q <= lane_mem[addr_in];
                end
            end
            assign rdata_out[l*LANE_W +: LANE_W] = rd_q;
        end
    endgenerate
endmodule

/* rtl/shared_hub_lock_semaphores.sv */
// central hub: eight lock semaphores plus serialized shared memory access
`timescale 1ns/1ps
module shared_hub_lock_semaphores
    import lock_pkg::*;
#(
    parameter int CORES = lock_pkg::CORES_DEFAULT,
    parameter int MEM_DEPTH = lock_pkg::MEM_DEPTH_DEFAULT,
    parameter int CW = $clog2(CORES),
    parameter int AW = $clog2(MEM_DEPTH)
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // per-core requests, held until acknowledged
    input wire logic [CORES-1:0] req_in,
    input wire logic [CORES-1:0][lock_pkg::OP_W-1:0] op_in,
    input wire logic [CORES-1:0][lock_pkg::LOCK_IDX_W-1:0] semaphore_index_in,
    input wire logic [CORES-1:0][AW-1:0] mem_addr_in,
    input wire logic [CORES-1:0][lock_pkg::LANES-1:0] mem_be_in,
    input wire logic [CORES-1:0][lock_pkg::WORD_W-1:0] mem_wdata_in,
    // answers
    output logic [CORES-1:0] ack_out,
    output logic [lock_pkg::RESULT_W-1:0] result_out,
    output logic [lock_pkg::WORD_W-1:0] mem_rdata_out,
    output logic [lock_pkg::LOCK_COUNT-1:0] lock_bits_out,
    output logic [lock_pkg::LOCK_COUNT-1:0] taken_bits_out
);
    import lock_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [LOCK_COUNT-1:0] lock;
        logic [LOCK_COUNT-1:0] taken;
        logic [CORES-1:0] ack;
        logic [RESULT_W-1:0] result;
    } hub_state_t;

    hub_state_t st_q;
    hub_state_t st_d;

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic [CORES-1:0] req_eff;
    logic win_valid;
    logic [CW-1:0] win_idx;
    logic [OP_W-1:0] win_op;
    logic [LOCK_IDX_W-1:0] win_lock;
    logic win_is_mem;
    logic prev_bit;
    logic free_found;
    logic [LOCK_IDX_W-1:0] free_idx;

    // a core just acknowledged still shows its old request for one cycle
    assign req_eff = req_in & ~st_q.ack;

    hub_rr_arbiter #(
        .N(CORES),
        .IW(CW)
    ) u_arb (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .req_in(req_eff),
        .grant_valid_out(win_valid),
        .grant_idx_out(win_idx)
    );

    assign win_op = op_in[win_idx];
    assign win_lock = semaphore_index_in[win_idx];
    assign win_is_mem = (win_op == OP_MEM_RD) || (win_op == OP_MEM_WR);
    assign prev_bit = st_q.lock[win_lock];

    // lowest free index wins an allocation
    always_comb begin
        free_found = 1'b0;
        free_idx = '0;
        for (int i = LOCK_COUNT - 1; i >= 0; i--) begin
            if (!st_q.taken[i]) begin
                free_found = 1'b1;
                free_idx = LOCK_IDX_W'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // lock operations, one granted core per cycle
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.ack = '0;
        if (win_valid) begin
            st_d.ack[win_idx] = 1'b1;
            case (win_op)
                OP_ALLOC: begin
                    if (free_found) begin
                        st_d.taken[free_idx] = 1'b1;
                        st_d.result = {1'b0, free_idx};
                    end else begin
                        st_d.result = RESULT_NONE;
                    end
                end
                OP_RELEASE: begin
                    // no owner kept, so any core may hand any lock back
                    st_d.taken[win_lock] = 1'b0;
                    st_d.result = RESULT_RESET;
                end
                OP_SET: begin
                    st_d.result = {3'h0, prev_bit};
                    st_d.lock[win_lock] = 1'b1;
                end
                OP_CLEAR: begin
                    st_d.result = {3'h0, prev_bit};
                    st_d.lock[win_lock] = 1'b0;
                end
                OP_MEM_RD, OP_MEM_WR: begin
                    st_d.result = RESULT_RESET;
                end
                default: begin
                    st_d.result = RESULT_NONE;
                end
            endcase
        end
        if (!resetn_in) begin
            st_d.lock = LOCK_BITS_RESET;
            st_d.taken = TAKEN_BITS_RESET;
            st_d.ack = '0;
            st_d.result = RESULT_RESET;
        end
    end

    always_ff @(posedge clk_in) begin
        st_q <= st_d;
    end

    // ------------------------------------------------------------
    // shared memory, one element access per cycle
    // ------------------------------------------------------------
    // lock bits are not consulted here: protection is cooperative only
    hub_shared_ram #(
        .DEPTH(MEM_DEPTH),
        .AW(AW)
    ) u_ram (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .en_in(win_valid && win_is_mem),
        .we_in(win_op == OP_MEM_WR),
        .addr_in(mem_addr_in[win_idx]),
        .be_in(mem_be_in[win_idx]),
        .wdata_in(mem_wdata_in[win_idx]),
        .rdata_out(mem_rdata_out)
    );

    assign ack_out = st_q.ack;
    assign result_out = st_q.result;
    assign lock_bits_out = st_q.lock;
    assign taken_bits_out = st_q.taken;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_grant(logic [OP_W-1:0] op);
        win_valid && (win_op == op);
    endsequence

    sequence s_answered;
        ##1 ($onehot(st_q.ack) && (st_q.ack == $past(req_eff & (1 << win_idx))));
    endsequence

    property p_one_grant;
        @(posedge clk_in) disable iff (!resetn_in)
        $onehot0(st_q.ack) && !(win_valid && (st_q.ack[win_idx] || !req_in[win_idx]));
    endproperty
    a_one_grant: assert property (p_one_grant)
        else $error("more than one core served or re-served");

    property p_alloc_ok;
        @(posedge clk_in) disable iff (!resetn_in)
        s_grant(OP_ALLOC) ##0 free_found |=> (st_q.result < 4'h8)
            && st_q.taken[st_q.result[2:0]]
            && ((($past(st_q.taken) >> st_q.result[2:0]) & 8'h01) == 8'h00)
            && ((~$past(st_q.taken) & ((8'h01 << st_q.result[2:0]) - 8'h01)) == 8'h00);
    endproperty
    a_alloc_ok: assert property (p_alloc_ok)
        else $error("allocation did not hand out a free index");

    property p_alloc_full;
        @(posedge clk_in) disable iff (!resetn_in)
        s_grant(OP_ALLOC) ##0 !free_found |=> (st_q.result == RESULT_NONE)
            && $stable(st_q.taken) && $stable(st_q.lock);
    endproperty
    a_alloc_full: assert property (p_alloc_full)
        else $error("full pool allocation not minus one or changed state");

    property p_set;
        @(posedge clk_in) disable iff (!resetn_in)
        s_grant(OP_SET) |=> st_q.lock[$past(win_lock)]
            && (st_q.result == {3'h0, $past(prev_bit)}) && $stable(st_q.taken);
    endproperty
    a_set: assert property (p_set)
        else $error("set did not force true or return old bit");

    property p_clear;
        @(posedge clk_in) disable iff (!resetn_in)
        s_grant(OP_CLEAR) |=> !st_q.lock[$past(win_lock)]
            && (st_q.result == {3'h0, $past(prev_bit)}) && $stable(st_q.taken);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not force false or return old bit");

    property p_release;
        @(posedge clk_in) disable iff (!resetn_in)
        s_grant(OP_RELEASE) |=> !st_q.taken[$past(win_lock)] && $stable(st_q.lock);
    endproperty
    a_release: assert property (p_release)
        else $error("release failed or disturbed lock bits");

    property p_release_reuse;
        @(posedge clk_in) disable iff (!resetn_in)
        s_grant(OP_RELEASE) ##1 (s_grant(OP_ALLOC) ##0 (st_q.taken == 8'h00))
            |=> (st_q.result == 4'h0);
    endproperty
    a_release_reuse: assert property (p_release_reuse)
        else $error("released pool not handed out from index zero");

    property p_mem_served;
        @(posedge clk_in) disable iff (!resetn_in)
        win_valid && win_is_mem |-> s_answered;
    endproperty
    a_mem_served: assert property (p_mem_served)
        else $error("memory access not answered one cycle after grant");

    property p_reset;
        @(posedge clk_in)
        !resetn_in |=> (st_q.lock == 8'h00) && (st_q.taken == 8'h00) && (st_q.ack == '0);
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not clear lock and allocation state");

    property p_idle_hold;
        @(posedge clk_in) disable iff (!resetn_in)
        !win_valid |=> $stable(st_q.lock) && $stable(st_q.taken) && (st_q.ack == '0);
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("lock state changed without a granted request");

    property p_illegal;
        @(posedge clk_in) disable iff (!resetn_in)
        win_valid && (win_op > OP_MEM_WR) |=> (st_q.result == RESULT_NONE)
            && $stable(st_q.lock) && $stable(st_q.taken);
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("undefined operation changed state or was not refused");

    property p_ack_pulse;
        @(posedge clk_in) disable iff (!resetn_in)
        (st_q.ack != '0) |=> ((st_q.ack & $past(st_q.ack)) == '0);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("a core was answered two cycles in a row");

    property p_alloc_count;
        @(posedge clk_in) disable iff (!resetn_in)
        s_grant(OP_ALLOC) ##0 free_found
            |=> ($countones(st_q.taken) == ($countones($past(st_q.taken)) + 1));
    endproperty
    a_alloc_count: assert property (p_alloc_count)
        else $error("allocation did not take exactly one lock");

    property p_mem_quiet;
        @(posedge clk_in) disable iff (!resetn_in)
        win_valid && win_is_mem |=> $stable(st_q.lock) && $stable(st_q.taken)
            && (st_q.result == RESULT_RESET);
    endproperty
    a_mem_quiet: assert property (p_mem_quiet)
        else $error("memory access touched lock state");

    property p_lock_src;
        @(posedge clk_in) disable iff (!resetn_in)
        !$stable(st_q.lock) |-> $past(win_valid)
            && (($past(win_op) == OP_SET) || ($past(win_op) == OP_CLEAR));
    endproperty
    a_lock_src: assert property (p_lock_src)
        else $error("lock bit changed without a set or clear");

    property p_taken_src;
        @(posedge clk_in) disable iff (!resetn_in)
        !$stable(st_q.taken) |-> $past(win_valid)
            && (($past(win_op) == OP_ALLOC) || ($past(win_op) == OP_RELEASE));
    endproperty
    a_taken_src: assert property (p_taken_src)
        else $error("allocation record changed without allocate or release");

    property p_answer_range;
        @(posedge clk_in) disable iff (!resetn_in)
        (st_q.ack != '0) |-> (st_q.result <= 4'h7) || (st_q.result == RESULT_NONE);
    endproperty
    a_answer_range: assert property (p_answer_range)
        else $error("answer outside index range and not minus one");
endmodule

/* tb/core_array_model.sv */
// partner model: cores that hold each lock or memory request until acked
`timescale 1ns/1ps
module core_array_model
    import lock_pkg::*;
#(
    parameter int N = 8,
    parameter int AW = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // commands from the bench
    input wire logic [N-1:0] go_in,
    input wire logic [lock_pkg::OP_W-1:0] cmd_op_in,
    input wire logic [lock_pkg::LOCK_IDX_W-1:0] cmd_idx_in,
    input wire logic [AW-1:0] cmd_addr_in,
    input wire logic [lock_pkg::LANES-1:0] cmd_be_in,
    input wire logic [lock_pkg::WORD_W-1:0] cmd_wd_in,
    input wire logic [1:0] cmd_lag_in,
    output logic [N-1:0] busy_out,
    // hub side
    input wire logic [N-1:0] ack_in,
    output logic [N-1:0] req_out,
    output logic [N-1:0][lock_pkg::OP_W-1:0] op_out,
    output logic [N-1:0][lock_pkg::LOCK_IDX_W-1:0] idx_out,
    output logic [N-1:0][AW-1:0] addr_out,
    output logic [N-1:0][lock_pkg::LANES-1:0] be_out,
    output logic [N-1:0][lock_pkg::WORD_W-1:0] wd_out
);
    logic [N-1:0] pend_q;
    logic [N-1:0][1:0] lag_q;

    assign busy_out = pend_q | req_out;

    initial begin
        {req_out, pend_q, lag_q, op_out, idx_out} = '0;
        {addr_out, be_out, wd_out} = '0;
    end

    always @(posedge clk_in) begin
        for (int c = 0; c < N; c++) begin
            if (!resetn_in) begin
                pend_q[c] <= 1'b0;
                req_out[c] <= 1'b0;
            end else if (go_in[c]) begin
                pend_q[c] <= 1'b1;
                lag_q[c] <= cmd_lag_in;
                op_out[c] <= cmd_op_in;
                idx_out[c] <= cmd_idx_in;
                addr_out[c] <= cmd_addr_in;
                be_out[c] <= cmd_be_in;
                wd_out[c] <= cmd_wd_in;
            end else if (pend_q[c] && lag_q[c] != 2'h0) begin
                // a slow core waits a few cycles before asking
                lag_q[c] <= lag_q[c] - 2'h1;
            end else if (pend_q[c]) begin
                pend_q[c] <= 1'b0;
                req_out[c] <= 1'b1;
            end else if (req_out[c] && ack_in[c]) begin
                // released index, address and write data must not keep showing the old value
                req_out[c] <= 1'b0;
                idx_out[c] <= ~idx_out[c];
                addr_out[c] <= ~addr_out[c];
                wd_out[c] <= ~wd_out[c];
            end
        end
    end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the lock semaphore hub
`timescale 1ns/1ps
module tb_top;
    import lock_pkg::*;
    localparam int AW = $clog2(MEM_DEPTH_DEFAULT);
    typedef struct {
        logic [7:0] core;
        logic [3:0] res;
        logic chk;
        logic [31:0] rd;
        logic [7:0] lk;
        logic [7:0] tk;
    } note_t;

    logic clk_in, resetn_in;
    logic [7:0] req, ack, go, busy, lock_bits, taken_bits;
    logic [7:0][2:0] op, idx;
    logic [7:0][AW-1:0] addr;
    logic [7:0][3:0] be;
    logic [7:0][31:0] wd;
    logic [3:0] result, c_be;
    logic [31:0] rdata, c_wd;
    logic [2:0] c_op, c_idx;
    logic [AW-1:0] c_addr;
    logic [1:0] c_lag;
    logic [7:0] lock_m, taken_m;
    logic [31:0] mem_m [MEM_DEPTH_DEFAULT];
    logic [MEM_DEPTH_DEFAULT-1:0] mv;
    note_t notes[$];
    note_t nt;
    int fail_count, num_checks, seed;

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    shared_hub_lock_semaphores dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .req_in(req),
        .op_in(op), .semaphore_index_in(idx), .mem_addr_in(addr), .mem_be_in(be),
        .mem_wdata_in(wd), .ack_out(ack), .result_out(result), .mem_rdata_out(rdata),
        .lock_bits_out(lock_bits), .taken_bits_out(taken_bits));

    core_array_model #(.N(8), .AW(AW)) cores_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .go_in(go), .cmd_op_in(c_op), .cmd_idx_in(c_idx), .cmd_addr_in(c_addr),
        .cmd_be_in(c_be), .cmd_wd_in(c_wd), .cmd_lag_in(c_lag), .busy_out(busy),
        .ack_in(ack), .req_out(req), .op_out(op), .idx_out(idx), .addr_out(addr),
        .be_out(be), .wd_out(wd));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // -----------------------------------------------------------
    // drive one command to the cores in mask, wait till all done
    // -----------------------------------------------------------
    task automatic issue(input logic [7:0] m, input logic [2:0] o, input logic [2:0] i,
                         input logic [AW-1:0] a, input logic [3:0] b, input logic [31:0] w);
        int n;
        n = 0;
        @(posedge clk_in);
        go <= m;
        {c_op, c_idx, c_addr, c_be, c_wd} <= {o, i, a, b, w};
        c_lag <= 2'($random(seed));
        @(posedge clk_in);
        go <= '0;
        // busy only rises after this edge, so look half a cycle later
        @(negedge clk_in);
        while ((busy & m) != 0 && n < 40) begin
            @(negedge clk_in);
            n++;
        end
        if ((busy & m) != 0) begin
            chk("wait", 0, 32'(busy));
            summarize();
        end
    endtask

    task automatic note_op(input int c, input logic [2:0] o, input logic [2:0] i,
                           input logic [AW-1:0] a, input logic [3:0] b, input logic [31:0] w);
        note_t n;
        n = '{8'(c), 4'h0, mv[a] && (o == OP_MEM_RD || o == OP_MEM_WR), mem_m[a], 8'h00, 8'h00};
        case (o)
            OP_ALLOC: begin
                n.res = RESULT_NONE;
                for (int k = 7; k >= 0; k--) if (!taken_m[k]) n.res = 4'(k);
                if (n.res != RESULT_NONE) taken_m[n.res[2:0]] = 1'b1;
            end
            OP_RELEASE: taken_m[i] = 1'b0;
            OP_SET, OP_CLEAR: begin
                n.res = {3'h0, lock_m[i]};
                lock_m[i] = (o == OP_SET);
            end
            OP_MEM_RD: ;
            OP_MEM_WR: begin
                for (int l = 0; l < 4; l++) if (b[l]) mem_m[a][l*8+:8] = w[l*8+:8];
                mv[a] = mv[a] | (b == 4'hF);
            end
            default: n.res = RESULT_NONE;
        endcase
        n.lk = lock_m;
        n.tk = taken_m;
        notes.push_back(n);
    endtask

    task automatic op1(input int c, input logic [2:0] o, input logic [2:0] i,
                       input logic [AW-1:0] a, input logic [3:0] b, input logic [31:0] w);
        note_op(c, o, i, a, b, w);
        issue(8'h01 << c, o, i, a, b, w);
    endtask

    always @(negedge clk_in) begin
        if (resetn_in && ack !== 8'h00) begin
            if (notes.size() == 0) begin
                chk("notes", 1, 0);
            end else begin
                nt = notes.pop_front();
                if (nt.core != 8'hFF) chk("ack", 32'h1 << nt.core, 32'(ack));
                chk("result", 32'(nt.res), 32'(result));
                if (nt.chk) chk("rdata", nt.rd, rdata);
                chk("lock", 32'(nt.lk), 32'(lock_bits));
                chk("taken", 32'(nt.tk), 32'(taken_bits));
            end
        end
    end

    initial begin
        note_t n;
        {fail_count, num_checks, lock_m, taken_m, mv} = '0;
        seed = 22;
        resetn_in = 1'b0;
        {go, c_op, c_idx, c_addr, c_be, c_wd, c_lag} = '0;
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(negedge clk_in);
        chk("lock_rst", 0, 32'(lock_bits));
        chk("taken_rst", 0, 32'(taken_bits));
        for (int i = 0; i < 8; i++) begin
            op1(i, OP_SET, 3'(i), 0, 0, 0);
            op1(i, OP_SET, 3'(i), 0, 0, 0);
            op1((i + 3) % 8, OP_CLEAR, 3'(i), 0, 0, 0);
            op1(i, OP_CLEAR, 3'(i), 0, 0, 0);
        end
        for (int i = 0; i < 9; i++) op1(i % 8, OP_ALLOC, 0, 0, 0, 0);
        op1(0, OP_SET, 3'd3, 0, 0, 0);
        op1(5, OP_RELEASE, 3'd3, 0, 0, 0);
        op1(6, OP_SET, 3'd3, 0, 0, 0);
        op1(0, OP_CLEAR, 3'd3, 0, 0, 0);
        op1(2, OP_ALLOC, 0, 0, 0, 0);
        op1(2, 3'h6, 3'd1, 0, 0, 0);
        op1(4, 3'h7, 3'd1, 0, 0, 0);
        // every core races for one lock: only the first sees it free
        lock_m[6] = 1'b1;
        n = '{8'hFF, 4'h0, 1'b0, 32'h0, lock_m, taken_m};
        for (int i = 0; i < 8; i++) begin
            n.res = (i == 0) ? 4'h0 : 4'h1;
            notes.push_back(n);
        end
        issue(8'hFF, OP_SET, 3'd6, 0, 0, 0);
        for (int a = 0; a < 4; a++) op1(a, OP_MEM_WR, 0, AW'(a), 4'hF, $random(seed));
        for (int k = 0; k < 24; k++) begin
            op1(k % 8, (k % 3 == 0) ? OP_MEM_RD : OP_MEM_WR, 0, AW'($random(seed) & 3),
                4'($random(seed)), $random(seed));
        end
        op1(1, OP_CLEAR, 3'd6, 0, 0, 0);
        for (int i = 0; i < 8; i++) op1(7 - i, OP_RELEASE, 3'(i), 0, 0, 0);
        // release and allocate back to back from two cores
        note_op(0, OP_RELEASE, 3'd0, 0, 0, 0);
        note_op(1, OP_ALLOC, 0, 0, 0, 0);
        @(posedge clk_in);
        go <= 8'h01;
        {c_op, c_idx, c_lag} <= {OP_RELEASE, 3'd0, 2'h0};
        @(posedge clk_in);
        go <= 8'h02;
        c_op <= OP_ALLOC;
        @(posedge clk_in);
        go <= '0;
        repeat (6) @(posedge clk_in);
        // reset in mid-run must free the pool again
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        resetn_in <= 1'b1;
        @(negedge clk_in);
        chk("taken_rst2", 0, 32'(taken_bits));
        chk("result_rst2", 0, 32'(result));
        {lock_m, taken_m} = '0;
        op1(4, OP_ALLOC, 0, 0, 0, 0);
        repeat (4) @(posedge clk_in);
        chk("pending", 0, notes.size());
        summarize();
    end
endmodule
